// ### src/can_pm_pkg.sv
// Constants and types shared by the CAN power mode and protection block
package can_pm_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int WAKE_FILTER_NS  = 2000;
    // Least time, so rounded up
    localparam int WAKE_FILTER_CYC =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W          = 7;
    localparam logic [FILT_W-1:0] FILT_LAST =
        FILT_W'(WAKE_FILTER_CYC - 1);
    // Last count of the recessive bits needed to join the bus (eleven bits)
    localparam logic [3:0] JOIN_LAST = 4'hA;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0   = 8'h00;
    localparam logic [7:0] OFS_CTRL1   = 8'h04;
    localparam logic [7:0] OFS_BTR0    = 8'h08;
    localparam logic [7:0] OFS_BTR1    = 8'h0C;
    localparam logic [7:0] OFS_ACCCTL  = 8'h10;
    localparam logic [7:0] OFS_PATTERN = 8'h14;
    localparam logic [7:0] OFS_MASK    = 8'h18;
    localparam logic [7:0] OFS_ERRCNT  = 8'h1C;
    localparam logic [7:0] OFS_STATUS  = 8'h20;

    // ==========================================================
    // Field positions in module_control_first
    localparam int B_SOFT_RESET = 0;
    localparam int B_SLEEP_REQ  = 1;
    localparam int B_SLEEP_ACK  = 2;
    localparam int B_WAKE_IE    = 3;
    localparam int B_TLINK_EN   = 4;
    // Field position in module_control_second
    localparam int B_WAKE_FILT  = 0;

    // ==========================================================
    // Reset values
    localparam logic       RST_SOFT_RESET = 1'b1;
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic       RECESSIVE      = 1'b1;

    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL     = 2'b00,
        MODE_SLEEP      = 2'b01,
        MODE_SOFT_RESET = 2'b10,
        MODE_POWER_DOWN = 2'b11
    } mode_t;

endpackage

// ### src/wake_if.sv
// Wake detector connection between controller and receive line filter
`timescale 1ns/1ps
interface wake_if;
    logic rx_pin;
    logic filter_en;
    logic armed;
    logic activity;

    modport filt (input rx_pin, input filter_en, input armed, output activity);
    modport user (output rx_pin, output filter_en, output armed, input activity);
endinterface

// ### src/wake_filter.sv
// Bus activity detector with optional low-pass filter on the receive line
`timescale 1ns/1ps
module wake_filter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Controller side
    wake_if.filt      wk
);

    typedef struct packed {
        logic [can_pm_pkg::FILT_W-1:0] cnt;
        logic                          activity;
    } filt_state_t;

    filt_state_t s;
    filt_state_t next_s;

    // ==========================================================
    // Dominant level detection
    always_comb begin
        next_s = s;
        next_s.activity = 1'b0;
        if (!wk.armed || wk.rx_pin == can_pm_pkg::RECESSIVE) begin
            next_s.cnt = '0;
        end else if (!wk.filter_en) begin
            next_s.activity = 1'b1;
        end else if (s.cnt == can_pm_pkg::FILT_LAST) begin
            next_s.activity = 1'b1; // see [RQ20]
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wk.activity = s.activity;

endmodule // wake_filter

// ### src/can_power_mode_protection.sv
// CAN controller mode, low-power sequencing and protection logic
//
// Contract
// [RQ1] Error counters ignore every write attempt
// [RQ2] Configuration registers writable only in soft reset
// [RQ3] Transmit pin recessive in any low-power mode
// [RQ4] Mode from CPU stop, acknowledge, soft reset
// [RQ5] Wake interrupt only with acknowledge and enable
// [RQ6] Sleep waits until no transmission remains
// [RQ7] Sleep waits for current reception to finish
// [RQ8] Sleep holds acknowledge, stops protocol clocks
// [RQ9] Bus-off recovery count pauses during sleep
// [RQ10] Sleep defers buffer copy and aborts
// [RQ11] Wake on activity, request clear, soft reset
// [RQ12] Request clear refused until acknowledge set
// [RQ13] Join bus after eleven recessive bits
// [RQ14] Deferred actions run after wake-up
// [RQ15] Soft reset halts transfers at once
// [RQ16] Software sleeps before soft reset or stop
// [RQ17] Power down aborts all, no register access
// [RQ18] Bus activity wakes MCU, then resynchronise
// [RQ19] CPU wait keeps block active, interrupts wake
// [RQ20] Optional glitch filter on receive line
// [RQ21] One-bit timer pulse after each valid frame
// [RQ22] Timer pulse gated by timer link enable
// [RQ23] Acknowledge cleared on leaving sleep
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module can_power_mode_protection (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // CPU state
    input  wire logic        cpu_stop,
    input  wire logic        cpu_wait,
    // Protocol engine status
    input  wire logic        tx_busy,
    input  wire logic        rx_busy,
    input  wire logic        bus_off,
    input  wire logic        bit_tick,
    input  wire logic        frame_valid,
    input  wire logic        engine_tx,
    input  wire logic [7:0]  rx_error_count,
    input  wire logic [7:0]  tx_error_count,
    input  wire logic        tx_irq,
    input  wire logic        rx_irq,
    input  wire logic        err_irq,
    // Protocol engine control
    output logic             protocol_clock_en,
    output logic             hold_deferred,
    output logic             engine_halt,
    output logic             bus_joined,
    output logic             recovery_count_en,
    // CAN pins
    input  wire logic        can_receive_pin,
    output logic             can_transmit_pin,
    // System events
    output logic             wakeup_irq,
    output logic             mcu_wake,
    output logic             timer_capture
);

    typedef struct packed {
        logic              soft_reset_request;
        logic              sleep_request_bit;
        logic              sleep_acknowledge_flag;
        logic              wakeup_irq_enable;
        logic              timer_link_enable;
        logic [7:0]        module_control_second;
        logic [7:0]        bus_timing_first;
        logic [7:0]        bus_timing_second;
        logic [7:0]        acceptance_control;
        logic [31:0]       acceptance_patterns;
        logic [31:0]       acceptance_masks;
        can_pm_pkg::mode_t mode;
        logic              joined;
        logic [3:0]        sync_cnt;
        logic              link_pulse;
        logic              tx_pin;
        logic              capture;
        logic              wake_irq;
        logic              wake_mcu;
        logic              clk_en;
        logic              hold;
        logic              halt;
        logic              recovery_en;
        logic              ready;
        logic              slverr;
        logic [31:0]       rdata;
    } state_t;

    state_t s;
    state_t next_s;

    wake_if wk ();

    logic setup_done;
    logic wr_go;
    logic bus_act;
    logic low_power;

    // ==========================================================
    // Wake detector
    assign wk.rx_pin    = can_receive_pin;
    assign wk.filter_en = s.module_control_second[can_pm_pkg::B_WAKE_FILT];
    assign wk.armed     = s.sleep_acknowledge_flag | cpu_stop;
    assign bus_act      = wk.activity;

    wake_filter wake_filter_inst (
        .clk     (clk),
        .reset_n (reset_n),
        .wk      (wk.filt)
    );

    // ==========================================================
    // Bus phase decode
    assign setup_done = psel & penable & ~s.ready;
    assign wr_go      = psel & penable & s.ready & pwrite & ~cpu_stop; // see [RQ17]

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;

        // Answer one cycle into the access phase
        next_s.ready  = setup_done;
        next_s.slverr = 1'b0;
        next_s.rdata  = '0;
        if (setup_done) begin
            if (cpu_stop) begin
                next_s.slverr = 1'b1; // see [RQ17]
            end else begin
                case (paddr)
                    can_pm_pkg::OFS_CTRL0: begin
                        next_s.rdata[can_pm_pkg::B_SOFT_RESET] = s.soft_reset_request;
                        next_s.rdata[can_pm_pkg::B_SLEEP_REQ]  = s.sleep_request_bit;
                        next_s.rdata[can_pm_pkg::B_SLEEP_ACK]  = s.sleep_acknowledge_flag;
                        next_s.rdata[can_pm_pkg::B_WAKE_IE]    = s.wakeup_irq_enable;
                        next_s.rdata[can_pm_pkg::B_TLINK_EN]   = s.timer_link_enable;
                    end
                    can_pm_pkg::OFS_CTRL1:   next_s.rdata[7:0] = s.module_control_second;
                    can_pm_pkg::OFS_BTR0:    next_s.rdata[7:0] = s.bus_timing_first;
                    can_pm_pkg::OFS_BTR1:    next_s.rdata[7:0] = s.bus_timing_second;
                    can_pm_pkg::OFS_ACCCTL:  next_s.rdata[7:0] = s.acceptance_control;
                    can_pm_pkg::OFS_PATTERN: next_s.rdata = s.acceptance_patterns;
                    can_pm_pkg::OFS_MASK:    next_s.rdata = s.acceptance_masks;
                    can_pm_pkg::OFS_ERRCNT:  next_s.rdata[15:0] =
                                                 {tx_error_count, rx_error_count};
                    can_pm_pkg::OFS_STATUS: begin
                        next_s.rdata[1:0] = s.mode;
                        next_s.rdata[2]   = s.joined;
                        next_s.rdata[7:4] = s.sync_cnt;
                    end
                    default: next_s.slverr = 1'b1;
                endcase
            end
        end

        // Register writes; counters have no write path
        if (wr_go) begin
            case (paddr)
                can_pm_pkg::OFS_CTRL0: begin
                    next_s.soft_reset_request = pwdata[can_pm_pkg::B_SOFT_RESET];
                    next_s.wakeup_irq_enable  = pwdata[can_pm_pkg::B_WAKE_IE];
                    next_s.timer_link_enable  = pwdata[can_pm_pkg::B_TLINK_EN];
                    if (pwdata[can_pm_pkg::B_SLEEP_REQ]) begin
                        next_s.sleep_request_bit = 1'b1;
                    end else if (s.sleep_acknowledge_flag) begin
                        next_s.sleep_request_bit = 1'b0; // see [RQ12]
                    end
                end
                can_pm_pkg::OFS_CTRL1: begin
                    if (s.soft_reset_request) begin
                        next_s.module_control_second = pwdata[7:0]; // see [RQ2]
                    end
                end
                can_pm_pkg::OFS_BTR0: begin
                    if (s.soft_reset_request) begin
                        next_s.bus_timing_first = pwdata[7:0]; // see [RQ2]
                    end
                end
                can_pm_pkg::OFS_BTR1: begin
                    if (s.soft_reset_request) begin
                        next_s.bus_timing_second = pwdata[7:0]; // see [RQ2]
                    end
                end
                can_pm_pkg::OFS_ACCCTL: begin
                    if (s.soft_reset_request) begin
                        next_s.acceptance_control = pwdata[7:0]; // see [RQ2]
                    end
                end
                can_pm_pkg::OFS_PATTERN: begin
                    if (s.soft_reset_request) begin
                        next_s.acceptance_patterns = pwdata; // see [RQ2]
                    end
                end
                can_pm_pkg::OFS_MASK: begin
                    if (s.soft_reset_request) begin
                        next_s.acceptance_masks = pwdata; // see [RQ2]
                    end
                end
                default: ; // see [RQ1]
            endcase
        end

        // Sleep handshake
        if (s.sleep_acknowledge_flag) begin
            if (bus_act || !next_s.sleep_request_bit || next_s.soft_reset_request) begin
                next_s.sleep_acknowledge_flag = 1'b0; // see [RQ11] [RQ23]
                if (bus_act) begin
                    next_s.sleep_request_bit = 1'b0;
                end
            end
        end else if (next_s.sleep_request_bit && !next_s.soft_reset_request
                     && !cpu_stop && !tx_busy && !rx_busy) begin
            next_s.sleep_acknowledge_flag = 1'b1; // see [RQ6] [RQ7] [RQ8]
        end

        // Mode decode
        if (cpu_stop) begin
            next_s.mode = can_pm_pkg::MODE_POWER_DOWN; // see [RQ4] [RQ17]
        end else if (next_s.soft_reset_request) begin
            next_s.mode = can_pm_pkg::MODE_SOFT_RESET; // see [RQ4] [RQ15]
        end else if (next_s.sleep_acknowledge_flag) begin
            next_s.mode = can_pm_pkg::MODE_SLEEP; // see [RQ4]
        end else begin
            next_s.mode = can_pm_pkg::MODE_NORMAL; // see [RQ4]
        end
        low_power = next_s.mode != can_pm_pkg::MODE_NORMAL;

        // Resynchronisation before taking part on the bus
        if (low_power) begin
            next_s.joined   = 1'b0;
            next_s.sync_cnt = '0;
        end else if (!s.joined && bit_tick) begin
            if (can_receive_pin != can_pm_pkg::RECESSIVE) begin
                next_s.sync_cnt = '0;
            end else if (s.sync_cnt == can_pm_pkg::JOIN_LAST) begin
                next_s.joined   = 1'b1; // see [RQ13] [RQ18]
                next_s.sync_cnt = '0;
            end else begin
                next_s.sync_cnt = s.sync_cnt + 1'b1;
            end
        end

        // Engine control
        next_s.tx_pin = (low_power || !s.joined) ? can_pm_pkg::RECESSIVE
                                                 : engine_tx; // see [RQ3]
        next_s.clk_en      = !low_power; // see [RQ8] [RQ17]
        next_s.hold        = next_s.mode == can_pm_pkg::MODE_SLEEP; // see [RQ10] [RQ14]
        next_s.halt        = next_s.mode == can_pm_pkg::MODE_SOFT_RESET
                           || next_s.mode == can_pm_pkg::MODE_POWER_DOWN; // see [RQ15]
        next_s.recovery_en = bus_off && !low_power; // see [RQ9]

        // Wake events
        next_s.wake_irq = bus_act && s.sleep_acknowledge_flag
                          && s.wakeup_irq_enable; // see [RQ5]
        next_s.wake_mcu = (cpu_stop && bus_act)
                          || (cpu_wait && (tx_irq || rx_irq || err_irq)); // see [RQ18] [RQ19]

        // Timer link pulse, one bit long
        if (frame_valid && s.joined && !low_power) begin
            next_s.link_pulse = 1'b1; // see [RQ21]
        end else if (bit_tick) begin
            next_s.link_pulse = 1'b0;
        end
        next_s.capture = s.link_pulse && s.timer_link_enable; // see [RQ22]
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s                       <= '0;
            s.soft_reset_request    <= can_pm_pkg::RST_SOFT_RESET;
            s.module_control_second <= can_pm_pkg::RST_BYTE;
            s.bus_timing_first      <= can_pm_pkg::RST_BYTE;
            s.bus_timing_second     <= can_pm_pkg::RST_BYTE;
            s.acceptance_control    <= can_pm_pkg::RST_BYTE;
            s.acceptance_patterns   <= can_pm_pkg::RST_WORD;
            s.acceptance_masks      <= can_pm_pkg::RST_WORD;
            s.mode                  <= can_pm_pkg::MODE_SOFT_RESET;
            s.tx_pin                <= can_pm_pkg::RECESSIVE;
            s.halt                  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata            = s.rdata;
    assign pready            = s.ready;
    assign pslverr           = s.slverr;
    assign protocol_clock_en = s.clk_en;
    assign hold_deferred     = s.hold;
    assign engine_halt       = s.halt;
    assign bus_joined        = s.joined;
    assign recovery_count_en = s.recovery_en;
    assign can_transmit_pin  = s.tx_pin;
    assign wakeup_irq        = s.wake_irq;
    assign mcu_wake          = s.wake_mcu;
    assign timer_capture     = s.capture;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    count_ro_a: assert property ( // see [RQ1]
        (wr_go && paddr == can_pm_pkg::OFS_ERRCNT) |=>
            $stable({s.soft_reset_request, s.wakeup_irq_enable, s.timer_link_enable,
                     s.module_control_second, s.bus_timing_first, s.bus_timing_second,
                     s.acceptance_control, s.acceptance_patterns, s.acceptance_masks}))
        else $error("error counter write changed state");

    config_lock_a: assert property ( // see [RQ2]
        (wr_go && !s.soft_reset_request) |=>
            $stable(s.bus_timing_first) && $stable(s.acceptance_masks))
        else $error("locked register changed");

    tx_recessive_a: assert property ( // see [RQ3]
        (s.mode != can_pm_pkg::MODE_NORMAL) |=> can_transmit_pin)
        else $error("transmit pin dominant in low power");

    stop_mode_a: assert property ( // see [RQ4]
        cpu_stop |=> s.mode == can_pm_pkg::MODE_POWER_DOWN)
        else $error("stop without power down");

    wake_gate_a: assert property ( // see [RQ5]
        wakeup_irq |-> $past(s.sleep_acknowledge_flag && s.wakeup_irq_enable))
        else $error("wake interrupt without enable");

    sleep_defer_a: assert property ( // see [RQ6]
        (!s.sleep_acknowledge_flag && (tx_busy || rx_busy)) |=>
            !s.sleep_acknowledge_flag)
        else $error("sleep entered while busy");

    request_hold_a: assert property ( // see [RQ12]
        (s.sleep_request_bit && !s.sleep_acknowledge_flag) |=> s.sleep_request_bit)
        else $error("sleep request cleared early");

    join_wait_a: assert property ( // see [RQ13]
        (!s.joined && s.sync_cnt == 4'h0) |=> !s.joined)
        else $error("joined before eleven bits");

    soft_halt_a: assert property ( // see [RQ15]
        (s.soft_reset_request && !cpu_stop) |-> engine_halt && !protocol_clock_en)
        else $error("engine runs in soft reset");

    capture_gate_a: assert property ( // see [RQ22]
        timer_capture |-> $past(s.timer_link_enable && s.link_pulse))
        else $error("timer capture without link enable");

endmodule // can_power_mode_protection

// ### bench/can_bus_model.sv
// Behavioural CAN bus: wired-AND of our transmit pin and other nodes
`timescale 1ns/1ps
module can_bus_model (
    // Clock
    input  wire logic       clk,
    // Other nodes
    input  wire logic       dom_go,
    input  wire logic [7:0] dom_len,
    // Line
    input  wire logic       can_transmit_pin,
    output logic            can_receive_pin
);
    logic [7:0] dom_cnt = 8'h00;

    // ==========================================
    // Other node holds the bus dominant for dom_len cycles
    always @(posedge clk) begin
        if (dom_go) begin
            dom_cnt <= dom_len;
        end else if (dom_cnt != 8'h00) begin
            dom_cnt <= dom_cnt - 8'h01;
        end
    end

    // Dominant wins; idle bus is recessive
    assign can_receive_pin = can_transmit_pin & (dom_cnt == 8'h00);
endmodule // can_bus_model

// ### bench/can_power_mode_protection_tb_top.sv
// Self-checking bench for the CAN mode and protection block
`timescale 1ns/1ps
module can_power_mode_protection_tb_top;
    logic clk = 1'b0, reset_n = 1'b0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, rx_err = 8'h00, tx_err = 8'h00, dom_len = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, cpu_stop = 0, cpu_wait = 0, tx_busy = 0, rx_busy = 0;
    logic bus_off = 0, bit_tick = 0, frame_valid = 0, engine_tx = 1, tx_irq = 0;
    logic rx_irq = 0, err_irq = 0;
    logic dom_go = 0, rx_pin, tx_pin, pclk_en, hold_def, halt, joined, rec_en;
    logic wk_irq, mcu_wake, tcap;
    logic [32:0] exp_q[$], msk_q[$], me, mm;
    logic [7:0]  d[6];
    logic [7:0]  ofs[6];
    int err_count = 0, samples_checked = 0, cyc = 0, wk_n = 0, mw_n = 0, cap_n = 0, base = 0;

    can_power_mode_protection can_power_mode_protection_inst (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
        .tx_busy(tx_busy), .rx_busy(rx_busy), .bus_off(bus_off), .bit_tick(bit_tick),
        .frame_valid(frame_valid), .engine_tx(engine_tx), .rx_error_count(rx_err),
        .tx_error_count(tx_err), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq),
        .protocol_clock_en(pclk_en), .hold_deferred(hold_def), .engine_halt(halt),
        .bus_joined(joined), .recovery_count_en(rec_en), .can_receive_pin(rx_pin),
        .can_transmit_pin(tx_pin), .wakeup_irq(wk_irq), .mcu_wake(mcu_wake),
        .timer_capture(tcap));
    can_bus_model can_bus_model_inst (.clk(clk), .dom_go(dom_go), .dom_len(dom_len),
        .can_transmit_pin(tx_pin), .can_receive_pin(rx_pin));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // APB master; expectation noted before the access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk) penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0, {1'b0, e}, 33'h1_FFFF_FFFF);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1, a, wd, 33'h0, 33'h1_0000_0000);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) bit_tick <= 1;
            @(posedge clk) bit_tick <= 0;
        end
        @(posedge clk);
    endtask
    task automatic dominant(input logic [7:0] n);
        dom_len <= n;
        dom_go <= 1;
        @(posedge clk) dom_go <= 0;
        repeat (n + 8'h06) @(posedge clk);
    endtask

    // ==========================================
    // Result watcher
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            me = exp_q.pop_front();
            mm = msk_q.pop_front();
            chk("apb read", me & mm, {pslverr, prdata} & mm);
        end
        wk_n <= wk_n + (wk_irq === 1'b1);
        mw_n <= mw_n + (mcu_wake === 1'b1);
        cap_n <= cap_n + (tcap === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        ofs = '{can_pm_pkg::OFS_CTRL1, can_pm_pkg::OFS_BTR0, can_pm_pkg::OFS_BTR1,
                can_pm_pkg::OFS_ACCCTL, can_pm_pkg::OFS_PATTERN, can_pm_pkg::OFS_MASK};
        void'($urandom(40955));
        repeat (3) @(posedge clk);
        reset_n <= 1;
        rx_err <= 8'($urandom);
        tx_err <= 8'($urandom);
        @(posedge clk);
        chk("tx pin", 1, tx_pin);
        chk("halt", 1, halt);
        rd(can_pm_pkg::OFS_CTRL0, 32'h01);
        rd(can_pm_pkg::OFS_STATUS, 32'h02);
        for (int i = 0; i < 6; i++) begin
            d[i] = (i == 0) ? 8'h00 : 8'($urandom);
            wr(ofs[i], {24'h0, d[i]});
        end
        wr(can_pm_pkg::OFS_CTRL0, 32'h18);
        rd(can_pm_pkg::OFS_CTRL0, 32'h18);
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], {24'h0, ~d[i]});
            apb(0, ofs[i], 0, {25'h0, d[i]}, 33'h1_0000_00FF);
        end
        wr(can_pm_pkg::OFS_ERRCNT, 32'hFFFF);
        rd(can_pm_pkg::OFS_ERRCNT, {16'h0, tx_err, rx_err});
        apb(0, 8'h40, 0, 33'h1_0000_0000, 33'h1_0000_0000);
        ticks(10);
        chk("joined early", 0, joined);
        ticks(1);
        chk("joined", 1, joined);
        engine_tx <= 0;
        bus_off <= 1;
        repeat (3) @(posedge clk);
        chk("tx follows", 0, tx_pin);
        chk("recovery", 1, rec_en);
        tx_busy <= 1;
        wr(can_pm_pkg::OFS_CTRL0, 32'h1A);
        wr(can_pm_pkg::OFS_CTRL0, 32'h18);
        rd(can_pm_pkg::OFS_CTRL0, 32'h1A);
        tx_busy <= 0;
        repeat (3) @(posedge clk);
        rd(can_pm_pkg::OFS_CTRL0, 32'h1E);
        chk("sleep pins", 3'b101, {tx_pin, pclk_en, hold_def});
        chk("sleep events", 2'b00, {rec_en, wk_n != 0});
        wr(can_pm_pkg::OFS_CTRL0, 32'h18);
        rd(can_pm_pkg::OFS_CTRL0, 32'h18);
        rx_busy <= 1;
        wr(can_pm_pkg::OFS_CTRL0, 32'h1A);
        repeat (3) @(posedge clk);
        rd(can_pm_pkg::OFS_CTRL0, 32'h1A);
        rx_busy <= 0;
        repeat (3) @(posedge clk);
        dominant(8'h03);
        chk("bus wake", 3'b100, {wk_n != 0, joined, hold_def});
        rd(can_pm_pkg::OFS_CTRL0, 32'h18);
        wr(can_pm_pkg::OFS_CTRL0, 32'h19);
        wr(can_pm_pkg::OFS_CTRL1, 32'h01);
        rd(can_pm_pkg::OFS_CTRL0, 32'h19);
        chk("soft reset", 3'b110, {halt, tx_pin, pclk_en});
        wr(can_pm_pkg::OFS_CTRL0, 32'h1A);
        repeat (3) @(posedge clk);
        dominant(8'h0A);
        rd(can_pm_pkg::OFS_CTRL0, 32'h1E);
        dominant(8'h3C);
        rd(can_pm_pkg::OFS_CTRL0, 32'h18);
        ticks(11);
        base = cap_n;
        frame_valid <= 1;
        @(posedge clk) frame_valid <= 0;
        ticks(1);
        chk("capture", 1, cap_n != base);
        wr(can_pm_pkg::OFS_CTRL0, 32'h08);
        base = cap_n;
        frame_valid <= 1;
        @(posedge clk) frame_valid <= 0;
        ticks(2);
        chk("capture off", 0, cap_n != base);
        wr(can_pm_pkg::OFS_CTRL0, 32'h0A);
        rd(can_pm_pkg::OFS_CTRL0, 32'h0E);
        engine_tx <= 0;
        cpu_stop <= 1;
        repeat (3) @(posedge clk);
        base = mw_n;
        chk("power down", 2'b11, {tx_pin, halt});
        apb(0, can_pm_pkg::OFS_CTRL0, 0, 33'h1_0000_0000, 33'h1_0000_0000);
        dominant(8'h3C);
        chk("stop wake", 1, mw_n != base);
        cpu_stop <= 0;
        cpu_wait <= 1;
        repeat (3) @(posedge clk);
        base = mw_n;
        {err_irq, rx_irq, tx_irq} <= 3'b001 << ($urandom % 3);
        repeat (3) @(posedge clk);
        chk("wait wake", 1, mw_n != base);
        stop_test();
    end
endmodule // can_power_mode_protection_tb_top
